// file: design/ats_pkg.sv
// constants and types shared by the two-wire setup slave
package ats_pkg;
	// own bus addresses of the two variants
	localparam logic [6:0] ADDR_FOUR   = 7'h64;
	localparam logic [6:0] ADDR_TWELVE = 7'h65;
	// top five bits of the high-speed master code
	localparam logic [4:0] MCODE_TOP   = 5'h01;
	// bit count of the acknowledge slot
	localparam logic [3:0] ACK_SLOT    = 4'h8;
	localparam logic [3:0] CNT_FIRST   = 4'h1;
	localparam logic [3:0] CNT_ZERO    = 4'h0;
	// field positions in a received address or write byte
	localparam int         REG_BIT     = 7;
	localparam int         CFG_RST_BIT = 1;
	localparam int         RW_BIT      = 0;
	// power-up values
	localparam logic [4:0] SETUP_RESET = 5'h00;
	localparam logic [6:0] CFG_RESET   = 7'h01;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	typedef struct packed {
		logic ref_select_hi;
		logic ref_select_mid;
		logic ref_select_lo;
		logic ext_clock;
		logic polarity_select;
	} ats_setup_t;

	typedef struct packed {
		logic [1:0] scan_select;
		logic [3:0] chan_select;
		logic       input_mode_select;
	} ats_config_t;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_WRITE,
		PH_READ,
		PH_SKIP
	} ats_phase_t;
endpackage

// file: design/ats_slave.sv
// two-wire slave with setup and configuration registers and result coding
// Operation
// - top bit one: setup byte, else configuration
// - setup bits 6..4 pick reference, reset zero
// - setup bit 1 zero restores configuration defaults
// - single-ended result measured against ground
// - differential result is pair difference
// - unipolar span zero to reference, negative clamps
// - bipolar two's complement, half reference span
// - single-ended forces unipolar coding
// - one bit per clock, nine per byte
// - data steady while clock high
// - master start and stop, device detects
// - repeated start keeps bus timing mode
// - acknowledge holds data low on ninth pulse
// - not-acknowledge leaves data high
// - idle until own address matched
// - fixed seven-bit address per variant
// - address low bit selects direction
// - matched address acknowledged one clock
// - power-up in fast/standard timing
// - master code: nack, high-speed until stop; here it ends at that stop, returns at the next one, and alternates per stop
module ats_slave
	import ats_pkg::*;
#(
	parameter bit TWELVE_CH = 1'b0
)(
	// system clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// two-wire link
	input  wire logic                 scl_clk,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	// converter side
	input  wire logic                 sample_valid,
	input  wire logic signed [8:0]    sample_diff,
	output ats_setup_t                conv_setup,
	output ats_config_t               conv_config,
	output logic                      bipolar_active,
	output logic                      shared_analog_ref_pin_ref,
	output logic                      high_speed_timing,
	output logic [7:0]                result_code
);

	localparam logic [6:0] OWN_ADDR = TWELVE_CH ? ADDR_TWELVE : ADDR_FOUR;

	function automatic logic [7:0] code_of(
		input logic signed [8:0] d,
		input logic              bip
	);
		logic [7:0] c;
		c = RESULT_RESET;
		if (bip)
		begin
			if (d > 9'sh07f)
				c = 8'h7f;
			else if (d < -9'sh080)
				c = 8'h80;
			else
				c = d[7:0];
		end
		else if (!d[8])
			c = d[7:0];
		return c;
	endfunction

	// link side state
	logic       start_tg_q;
	logic       stop_tg_q;
	logic       frame_mark_q;
	logic       stop_mark_q;
	logic       start_seen_q;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	ats_phase_t ph_q;
	ats_phase_t ph_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] hold_q;
	logic       wr_tg_q;
	logic       hs_q;
	logic       hs_ref_q;
	logic       oe_q;
	logic       oe_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;

	// system side state
	logic [2:0]  wr_s_q;
	logic [1:0]  busy_s_q;
	logic [1:0]  hs_s_q;
	ats_setup_t  setup_q;
	ats_config_t cfg_q;
	logic [7:0]  result_q;

	wire start_new = start_tg_q ^ start_seen_q;
	wire in_ack    = cnt_q == ACK_SLOT;
	wire addr_hit  = shift_q[7:1] == OWN_ADDR;
	wire mcode_hit = shift_q[7:3] == MCODE_TOP;
	wire link_busy = frame_mark_q ^ stop_mark_q;
	wire hs_link   = hs_q & (hs_ref_q == stop_tg_q);
	wire wr_edge   = wr_s_q[2] ^ wr_s_q[1];
	wire is_setup  = hold_q[REG_BIT];
	wire bip_eff   = setup_q.polarity_select & ~cfg_q.input_mode_select;
	wire [7:0] code_new = code_of(sample_diff, bip_eff);

	// start and stop are data edges while the clock is high, so they are
	// caught by flip-flops clocked on the data line itself
	always_ff @(negedge sda_in or posedge rst)
		if (rst)
		begin
			start_tg_q   <= 1'b0;
			frame_mark_q <= 1'b0;
		end
		else if (scl_clk)
		begin
			start_tg_q   <= ~start_tg_q;
			// a repeated start leaves the frame open
			frame_mark_q <= ~stop_mark_q;
		end

	// a stop on an idle bus leaves the marks equal, so it opens no frame
	always_ff @(posedge sda_in or posedge rst)
		if (rst)
		begin
			stop_tg_q   <= 1'b0;
			stop_mark_q <= 1'b0;
		end
		else if (scl_clk)
		begin
			stop_tg_q   <= ~stop_tg_q;
			stop_mark_q <= frame_mark_q;
		end

	// bit framing, sampled on the rising clock edge
	always_comb
	begin
		cnt_d   = cnt_q + CNT_FIRST;
		shift_d = {shift_q[6:0], sda_in};
		ph_d    = ph_q;
		if (start_new)
		begin
			// a repeated start restarts framing, timing mode untouched
			cnt_d   = CNT_FIRST;
			shift_d = {7'h00, sda_in};
			ph_d    = PH_ADDR;
		end
		else if (in_ack)
		begin
			cnt_d   = CNT_ZERO;
			shift_d = shift_q;
			case (ph_q)
				PH_ADDR:
					if (addr_hit)
						ph_d = shift_q[RW_BIT] ? PH_READ : PH_WRITE;
					else
						ph_d = PH_SKIP;
				PH_READ:
					if (sda_in)
						ph_d = PH_SKIP;
				default:
					ph_d = ph_q;
			endcase
		end
	end

	always_ff @(posedge scl_clk or posedge rst)
		if (rst)
		begin
			start_seen_q <= 1'b0;
			cnt_q        <= CNT_ZERO;
			ph_q         <= PH_SKIP;
			shift_q      <= 8'h00;
		end
		else
		begin
			start_seen_q <= start_tg_q;
			cnt_q        <= cnt_d;
			ph_q         <= ph_d;
			shift_q      <= shift_d;
		end

	// a write byte is handed over only once its acknowledge pulse is on
	always_ff @(posedge scl_clk or posedge rst)
		if (rst)
		begin
			hold_q   <= 8'h00;
			wr_tg_q  <= 1'b0;
			hs_q     <= 1'b0;
			hs_ref_q <= 1'b0;
		end
		else if (in_ack && !start_new)
		begin
			if (ph_q == PH_WRITE)
			begin
				hold_q  <= shift_q;
				wr_tg_q <= ~wr_tg_q;
			end
			if (ph_q == PH_ADDR && mcode_hit)
			begin
				hs_q     <= 1'b1;
				hs_ref_q <= stop_tg_q;
			end
		end

	// data line drive, changed only while the clock is low
	always_comb
	begin
		oe_d = 1'b0;
		tx_d = {tx_q[6:0], 1'b0};
		if (start_new)
			oe_d = 1'b0;
		else if (in_ack)
			oe_d = (ph_q == PH_ADDR && addr_hit)
				|| ph_q == PH_WRITE;
		else if (ph_q == PH_READ)
		begin
			if (cnt_q == CNT_ZERO)
			begin
				tx_d = {result_q[6:0], 1'b0};
				oe_d = ~result_q[7];
			end
			else
				oe_d = ~tx_q[7];
		end
	end

	always_ff @(negedge scl_clk or posedge rst)
		if (rst)
		begin
			oe_q <= 1'b0;
			tx_q <= 8'h00;
		end
		else
		begin
			oe_q <= oe_d;
			tx_q <= tx_d;
		end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;

	// crossings into the system clock
	always_ff @(posedge clock or posedge rst)
		if (rst)
		begin
			wr_s_q   <= 3'h0;
			busy_s_q <= 2'h0;
			hs_s_q   <= 2'h0;
		end
		else
		begin
			wr_s_q   <= {wr_s_q[1:0], wr_tg_q};
			busy_s_q <= {busy_s_q[0], link_busy};
			hs_s_q   <= {hs_s_q[0], hs_link};
		end

	// hold_q is stable when the synchronised toggle arrives
	always_ff @(posedge clock or posedge rst)
		if (rst)
		begin
			setup_q <= ats_setup_t'(SETUP_RESET);
			cfg_q   <= ats_config_t'(CFG_RESET);
		end
		else if (wr_edge)
		begin
			if (is_setup)
			begin
				setup_q <= ats_setup_t'(hold_q[6:2]);
				if (!hold_q[CFG_RST_BIT])
					cfg_q <= ats_config_t'(CFG_RESET);
			end
			else
				cfg_q <= ats_config_t'(hold_q[6:0]);
		end

	// result is frozen during a frame: the link reads it as a static word
	always_ff @(posedge clock or posedge rst)
		if (rst)
			result_q <= RESULT_RESET;
		else if (sample_valid && !busy_s_q[1])
			result_q <= code_new;

	assign conv_setup                = setup_q;
	assign conv_config               = cfg_q;
	assign bipolar_active            = bip_eff;
	assign shared_analog_ref_pin_ref = setup_q.ref_select_mid;
	assign high_speed_timing         = hs_s_q[1];
	assign result_code               = result_q;

	chk_setup_commit: assert property (
		@(posedge clock) disable iff (rst)
		wr_edge && is_setup |=> setup_q == ats_setup_t'($past(hold_q[6:2])))
		else $error("setup byte not stored");

	chk_setup_stable: assert property (
		@(posedge clock) disable iff (rst)
		!(wr_edge && is_setup) |=> $stable(setup_q))
		else $error("setup changed without a setup write");

	chk_cfg_restore: assert property (
		@(posedge clock) disable iff (rst)
		wr_edge && is_setup && !hold_q[CFG_RST_BIT]
		|=> cfg_q == ats_config_t'(CFG_RESET))
		else $error("configuration not restored");

	chk_cfg_write: assert property (
		@(posedge clock) disable iff (rst)
		wr_edge && !is_setup |=> cfg_q == ats_config_t'($past(hold_q[6:0])))
		else $error("configuration byte not stored");

	chk_uni_clamp: assert property (
		@(posedge clock) disable iff (rst)
		sample_valid && !busy_s_q[1] && !bip_eff && sample_diff[8]
		|=> result_q == 8'h00)
		else $error("negative unipolar input not clamped");

	chk_single_uni: assert property (
		@(posedge clock) disable iff (rst)
		sample_valid && !busy_s_q[1] && cfg_q.input_mode_select
		&& !sample_diff[8]
		|=> result_q == $past(sample_diff[7:0]))
		else $error("single-ended input coded bipolar");

	chk_bip_code: assert property (
		@(posedge clock) disable iff (rst)
		sample_valid && !busy_s_q[1] && bip_eff
		&& sample_diff < 9'sh080 && sample_diff >= -9'sh080
		|=> result_q == $past(sample_diff[7:0]))
		else $error("bipolar code not two's complement");

	chk_addr_ack: assert property (
		@(posedge scl_clk) disable iff (rst)
		in_ack && ph_q == PH_ADDR && addr_hit && !start_new
		|-> sda_oe ##1 (ph_q == (shift_q[RW_BIT] ? PH_READ : PH_WRITE)))
		else $error("own address not acknowledged");

	chk_mcode_nack: assert property (
		@(posedge scl_clk) disable iff (rst)
		in_ack && ph_q == PH_ADDR && mcode_hit && !start_new
		|-> !sda_oe ##1 hs_q)
		else $error("master code not refused or mode not set");

	chk_foreign_quiet: assert property (
		@(posedge scl_clk) disable iff (rst)
		ph_q == PH_SKIP && !in_ack |=> !sda_oe || start_new)
		else $error("device drives data without address match");

	chk_skip_hold: assert property (
		@(posedge scl_clk) disable iff (rst)
		ph_q == PH_SKIP && !start_new |=> ph_q == PH_SKIP)
		else $error("device left idle without a start");

	chk_write_ack: assert property (
		@(posedge scl_clk) disable iff (rst)
		in_ack && ph_q == PH_WRITE && !start_new |-> sda_oe)
		else $error("write byte not acknowledged");

	chk_read_release: assert property (
		@(posedge scl_clk) disable iff (rst)
		in_ack && ph_q == PH_READ |-> !sda_oe)
		else $error("device holds data in the master ack slot");

	chk_cfg_stable: assert property (
		@(posedge clock) disable iff (rst)
		!wr_edge |=> $stable(cfg_q))
		else $error("configuration changed without a write");

	chk_busy_hold: assert property (
		@(posedge clock) disable iff (rst)
		busy_s_q[1] |=> $stable(result_q))
		else $error("result changed during a frame");

endmodule // ats_slave

// file: tb/ats_bus_master.sv
// bus master model: drives the link clock and pulls the data line low
module ats_bus_master (
	// link lines
	output logic      scl_clk,
	output logic      sda_pull,
	input  wire logic sda_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// the clock stands high between frames; it does not run free
	initial
	begin
		scl_clk  = 1'b1;
		sda_pull = 1'b0;
	end

	// also used as a repeated start, entered with the clock low
	task automatic begin_frame();
		// the odd offset keeps the link out of step with the system clock
		#7 sda_pull = 1'b0;
		#20 scl_clk = 1'b1;
		#20 sda_pull = 1'b1;
		#20 scl_clk = 1'b0;
		#20;
	endtask

	task automatic end_frame();
		sda_pull = 1'b1;
		#20 scl_clk = 1'b1;
		#20 sda_pull = 1'b0;
		#20;
	endtask

	// data changes only mid-low so a high phase never looks like a condition
	task automatic bit_x(input logic b, output logic s);
		sda_pull = ~b;
		#20 scl_clk = 1'b1;
		#20 s = sda_line;
		#20 scl_clk = 1'b0;
		#20;
	endtask

	// eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic n);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(a, n);
	endtask
endmodule // ats_bus_master

// file: tb/tb_ats_slave.sv
// self-checking bench for the two-wire setup slave
module tb_ats_slave;
	timeunit 1ns;
	timeprecision 100ps;
	import ats_pkg::*;

	logic              clock, rst, scl_clk, sda_pull, sample_valid;
	logic signed [8:0] sample_diff;
	logic              sda_out, sda_oe, bipolar_active, pin_ref, hs;
	ats_setup_t        conv_setup;
	ats_config_t       conv_config;
	logic [7:0]        result_code, got;
	logic              ack, bip_x;
	int                miscompares, comparisons;
	logic [7:0]        set_b [3] = '{8'h86, 8'h82, 8'h86};
	logic [7:0]        cfg_b [3] = '{8'h00, 8'h00, 8'h01};
	logic signed [8:0] smp [3] = '{-9'sd200, 9'sd200, -9'sd5};
	// pulled-up line: high unless some party pulls it
	wire logic         sda_line = ~((sda_oe & ~sda_out) | sda_pull);

	ats_slave ats_slave_inst (
		.clock(clock), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .sample_valid(sample_valid),
		.sample_diff(sample_diff), .conv_setup(conv_setup),
		.conv_config(conv_config), .bipolar_active(bipolar_active),
		.shared_analog_ref_pin_ref(pin_ref), .high_speed_timing(hs),
		.result_code(result_code)
	);

	ats_bus_master ats_bus_master_inst (
		.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_line(sda_line)
	);

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic summarize();
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] a);
		comparisons++;
		if (a !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, a);
			miscompares++;
		end
	endtask

	// send one byte and compare the acknowledge slot (0 = acknowledged)
	task automatic send(input logic [7:0] d, input logic n);
		ats_bus_master_inst.xfer(d, 1'b1, got, ack);
		check("ack slot", {7'h0, n}, {7'h0, ack});
	endtask

	// full write frame, then room for the commit to cross domains
	task automatic wr(input logic [7:0] d);
		ats_bus_master_inst.begin_frame();
		send({ADDR_FOUR, 1'b0}, 1'b0);
		send(d, 1'b0);
		ats_bus_master_inst.end_frame();
		repeat (10) @(negedge clock);
	endtask

	task automatic sample(input logic signed [8:0] d, input logic [7:0] e);
		sample_valid = 1'b1;
		sample_diff  = d;
		@(negedge clock);
		sample_valid = 1'b0;
		@(negedge clock);
		check("result_code", e, result_code);
	endtask

	function automatic logic [7:0] code(logic signed [8:0] d, logic b);
		if (b && d < -128)
			return 8'h80;
		if (b && d > 127)
			return 8'h7f;
		if (!b && d < 0)
			return 8'h00;
		return d[7:0];
	endfunction

	initial
	begin
		rst          = 1'b1;
		sample_valid = 1'b0;
		sample_diff  = '0;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		check("setup", 8'h00, {3'h0, conv_setup});
		check("config", 8'h01, {1'h0, conv_config});
		check("hs", 8'h00, {7'h0, hs});
		// other variant's address is ignored; the master then sends a stop
		ats_bus_master_inst.begin_frame();
		send({ADDR_TWELVE, 1'b0}, 1'b1);
		ats_bus_master_inst.end_frame();
		wr(8'h3e);
		check("config", 8'h3e, {1'h0, conv_config});
		wr(8'hbe);
		check("setup", 8'h0f, {3'h0, conv_setup});
		check("config", 8'h3e, {1'h0, conv_config});
		check("pin_ref", 8'h01, {7'h0, pin_ref});
		wr(8'h81);
		check("config", 8'h01, {1'h0, conv_config});
		check("setup", 8'h00, {3'h0, conv_setup});
		for (int m = 0; m < 3; m++)
		begin
			wr(set_b[m]);
			wr(cfg_b[m]);
			bip_x = set_b[m][2] & ~cfg_b[m][0];
			check("bipolar", {7'h0, bip_x}, {7'h0, bipolar_active});
			for (int k = 0; k < 3; k++)
				sample(smp[k], code(smp[k], bip_x));
		end
		sample(9'sd77, 8'h4d);
		ats_bus_master_inst.begin_frame();
		send({ADDR_FOUR, 1'b1}, 1'b0);
		ats_bus_master_inst.xfer(8'hff, 1'b0, got, ack);
		check("read", 8'h4d, got);
		ats_bus_master_inst.xfer(8'hff, 1'b1, got, ack);
		check("read", 8'h4d, got);
		ats_bus_master_inst.end_frame();
		// master code: refused, then high-speed until the stop
		ats_bus_master_inst.begin_frame();
		send(8'h08, 1'b1);
		repeat (10) @(negedge clock);
		check("hs", 8'h01, {7'h0, hs});
		// samples are dropped while the frame stays open
		sample(9'sd3, 8'h4d);
		ats_bus_master_inst.begin_frame();
		send({ADDR_FOUR, 1'b0}, 1'b0);
		check("hs", 8'h01, {7'h0, hs});
		sample(9'sd3, 8'h4d);
		ats_bus_master_inst.end_frame();
		repeat (10) @(negedge clock);
		check("hs", 8'h00, {7'h0, hs});
		sample(9'sd3, 8'h03);
		summarize();
	end

	// the whole run needs well under a tenth of this
	initial
	begin
		#500us;
		miscompares++;
		summarize();
	end
endmodule // tb_ats_slave
